//--- bbe_exec.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bbe_exec #(
  parameter int unsigned PC_W = 16
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  input  wire logic [bbe_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bbe_pkg::APB_W-1:0]     pwdata,
  output logic                               pready,
  output logic [bbe_pkg::APB_W-1:0]          prdata,
  output logic                               pslverr,
  output logic [bbe_pkg::CMD_IO_W-1:0]       io_addr,
  output logic                               io_re,
  input  wire logic [bbe_pkg::DATA_W-1:0]    io_rdata,
  output logic                               io_we,
  output logic [bbe_pkg::DATA_W-1:0]         io_wdata
);

  bbe_pkg::bbe_state_type          state,     next_state;
  bbe_pkg::bbe_op_type             op,        next_op;
  logic [bbe_pkg::CMD_SEL_W-1:0]   sel,       next_sel;
  logic [bbe_pkg::CMD_K_W-1:0]     koff,      next_koff;
  logic                            long_next, next_long_next;
  logic [PC_W-1:0]                 pc,        next_pc;
  logic [bbe_pkg::DATA_W-1:0]      flags,     next_flags;
  logic [bbe_pkg::DATA_W-1:0]      operand,   next_operand;
  logic [1:0]                      hold_cnt,  next_hold_cnt;
  logic [1:0]                      cycles,    next_cycles;
  logic                            taken,     next_taken;
  logic                            rd_valid,  next_rd_valid;
  logic [bbe_pkg::CMD_IO_W-1:0]    next_io_addr;
  logic [bbe_pkg::DATA_W-1:0]      next_io_wdata;
  logic [bbe_pkg::APB_W-1:0]       next_prdata;

  logic                            is_branch;
  logic                            cond;
  logic                            is_shift;
  logic [bbe_pkg::DATA_W-1:0]      shift_res;
  logic                            shift_c;
  logic [PC_W-1:0]                 k_ext;
  logic [PC_W-1:0]                 target;
  logic [bbe_pkg::DATA_W-1:0]      bit_mask;
  logic                            busy;
  logic                            access;
  logic                            addr_ok;
  logic                            cmd_ok;
  logic                            wr_en;
  logic [bbe_pkg::CMD_OP_W-1:0]    wr_op;

  // Bus side decode; a frozen core holds the transfer open, and a read
  // whose setup edge was frozen waits one more cycle for its data
  assign pready  = clk_en && (pwrite || rd_valid);
  assign busy    = (state != bbe_pkg::st_idle);
  assign access  = psel && penable;
  assign wr_op   = pwdata[bbe_pkg::CMD_OP_LSB +: bbe_pkg::CMD_OP_W];
  assign cmd_ok  = (wr_op < bbe_pkg::op_illegal);
  assign addr_ok = (paddr == bbe_pkg::REG_CMD) || (paddr == bbe_pkg::REG_PC)
                || (paddr == bbe_pkg::REG_FLAGS) || (paddr == bbe_pkg::REG_OPERAND)
                || (paddr == bbe_pkg::REG_STATUS);

  // Writes refused while executing, to status, or with a bad opcode
  always_comb
  begin
    pslverr = 1'b0;
    if (access)
    begin
      if (!addr_ok)
        pslverr = 1'b1;
      else if (pwrite && (busy || (paddr == bbe_pkg::REG_STATUS)))
        pslverr = 1'b1;
      else if (pwrite && (paddr == bbe_pkg::REG_CMD) && !cmd_ok)
        pslverr = 1'b1;
    end
  end

  assign wr_en = access && pwrite && !pslverr;

  // Signed offset widened to the program counter
  assign k_ext  = {{(PC_W - bbe_pkg::CMD_K_W){koff[bbe_pkg::CMD_K_W-1]}}, koff};
  assign target = pc + PC_W'(bbe_pkg::PC_STEP) + k_ext;
  assign bit_mask = {{(bbe_pkg::DATA_W-1){1'b0}}, 1'b1} << sel;

  // Branch condition per opcode
  always_comb
  begin
    is_branch = 1'b1;
    cond      = 1'b0;
    case (op)
      bbe_pkg::op_branch_status_bit_set:    cond = flags[sel];
      bbe_pkg::op_branch_status_bit_clear:  cond = !flags[sel];
      bbe_pkg::op_branch_when_equal:        cond = flags[bbe_pkg::FLAG_Z];
      bbe_pkg::op_branch_when_not_equal:    cond = !flags[bbe_pkg::FLAG_Z];
      bbe_pkg::op_branch_carry_set:         cond = flags[bbe_pkg::FLAG_C];
      bbe_pkg::op_branch_when_lower:        cond = flags[bbe_pkg::FLAG_C];
      bbe_pkg::op_branch_carry_clear:       cond = !flags[bbe_pkg::FLAG_C];
      bbe_pkg::op_branch_same_or_higher:    cond = !flags[bbe_pkg::FLAG_C];
      bbe_pkg::op_branch_negative:          cond = flags[bbe_pkg::FLAG_N];
      bbe_pkg::op_branch_positive:          cond = !flags[bbe_pkg::FLAG_N];
      bbe_pkg::op_branch_signed_greater_equal:
        cond = !(flags[bbe_pkg::FLAG_N] ^ flags[bbe_pkg::FLAG_V]);
      bbe_pkg::op_branch_signed_less:
        cond = flags[bbe_pkg::FLAG_N] ^ flags[bbe_pkg::FLAG_V];
      bbe_pkg::op_branch_half_carry_set:    cond = flags[bbe_pkg::FLAG_H];
      bbe_pkg::op_branch_half_carry_clear:  cond = !flags[bbe_pkg::FLAG_H];
      bbe_pkg::op_branch_transfer_flag_set: cond = flags[bbe_pkg::FLAG_T];
      bbe_pkg::op_branch_transfer_flag_clear: cond = !flags[bbe_pkg::FLAG_T];
      bbe_pkg::op_branch_overflow_set:      cond = flags[bbe_pkg::FLAG_V];
      bbe_pkg::op_branch_overflow_clear:    cond = !flags[bbe_pkg::FLAG_V];
      bbe_pkg::op_branch_irq_enabled:       cond = flags[bbe_pkg::FLAG_I];
      bbe_pkg::op_branch_irq_disabled:      cond = !flags[bbe_pkg::FLAG_I];
      default:                              is_branch = 1'b0;
    endcase
  end

  // Shifter; the old carry feeds the rotates
  always_comb
  begin
    is_shift  = 1'b1;
    shift_res = operand;
    shift_c   = flags[bbe_pkg::FLAG_C];
    case (op)
      bbe_pkg::op_shift_left_logical:
      begin
        shift_res = {operand[bbe_pkg::DATA_W-2:0], 1'b0};
        shift_c   = operand[bbe_pkg::DATA_W-1];
      end
      bbe_pkg::op_shift_right_logical:
      begin
        shift_res = {1'b0, operand[bbe_pkg::DATA_W-1:1]};
        shift_c   = operand[0];
      end
      bbe_pkg::op_rotate_left_carry:
      begin
        shift_res = {operand[bbe_pkg::DATA_W-2:0], flags[bbe_pkg::FLAG_C]};
        shift_c   = operand[bbe_pkg::DATA_W-1];
      end
      bbe_pkg::op_rotate_right_carry:
      begin
        shift_res = {flags[bbe_pkg::FLAG_C], operand[bbe_pkg::DATA_W-1:1]};
        shift_c   = operand[0];
      end
      default: is_shift = 1'b0;
    endcase
  end

  // I/O strobes: read in the first cycle, write-back in the second
  assign io_re = (state == bbe_pkg::st_exec) && ((op == bbe_pkg::op_skip_io_bit_set)
              || (op == bbe_pkg::op_set_io_bit) || (op == bbe_pkg::op_clear_io_bit));
  assign io_we = (state == bbe_pkg::st_io_write);

  // Next values of the whole core state
  always_comb
  begin
    next_state     = state;
    next_op        = op;
    next_sel       = sel;
    next_koff      = koff;
    next_long_next = long_next;
    next_pc        = pc;
    next_flags     = flags;
    next_operand   = operand;
    next_hold_cnt  = hold_cnt;
    next_cycles    = cycles;
    next_taken     = taken;
    next_io_addr   = io_addr;
    next_io_wdata  = io_wdata;
    next_prdata    = prdata;
    next_rd_valid  = psel && !pwrite && !(penable && rd_valid);
    // Read data latched once per read, then held until the access ends
    if (psel && !pwrite && !rd_valid)
    begin
      next_prdata = '0;
      case (paddr)
        bbe_pkg::REG_PC:      next_prdata[PC_W-1:0] = pc;
        bbe_pkg::REG_FLAGS:   next_prdata[bbe_pkg::DATA_W-1:0] = flags;
        bbe_pkg::REG_OPERAND: next_prdata[bbe_pkg::DATA_W-1:0] = operand;
        bbe_pkg::REG_STATUS:
        begin
          next_prdata[bbe_pkg::STAT_BUSY_BIT]  = busy;
          next_prdata[bbe_pkg::STAT_TAKEN_BIT] = taken;
          next_prdata[bbe_pkg::STAT_CYC_LSB +: bbe_pkg::STAT_CYC_W] = cycles;
        end
        bbe_pkg::REG_CMD:
        begin
          next_prdata[bbe_pkg::CMD_OP_LSB +: bbe_pkg::CMD_OP_W]   = op;
          next_prdata[bbe_pkg::CMD_SEL_LSB +: bbe_pkg::CMD_SEL_W] = sel;
          next_prdata[bbe_pkg::CMD_K_LSB +: bbe_pkg::CMD_K_W]     = koff;
          next_prdata[bbe_pkg::CMD_IO_LSB +: bbe_pkg::CMD_IO_W]   = io_addr;
          next_prdata[bbe_pkg::CMD_LONG_BIT]                      = long_next;
        end
        default: next_prdata = '0;
      endcase
    end
    // Register writes only land while idle
    if (wr_en)
    begin
      case (paddr)
        bbe_pkg::REG_PC:      next_pc      = pwdata[PC_W-1:0];
        bbe_pkg::REG_FLAGS:   next_flags   = pwdata[bbe_pkg::DATA_W-1:0];
        bbe_pkg::REG_OPERAND: next_operand = pwdata[bbe_pkg::DATA_W-1:0];
        bbe_pkg::REG_CMD:
        begin
          next_op        = bbe_pkg::bbe_op_type'(wr_op);
          next_sel       = pwdata[bbe_pkg::CMD_SEL_LSB +: bbe_pkg::CMD_SEL_W];
          next_koff      = pwdata[bbe_pkg::CMD_K_LSB +: bbe_pkg::CMD_K_W];
          next_io_addr   = pwdata[bbe_pkg::CMD_IO_LSB +: bbe_pkg::CMD_IO_W];
          next_long_next = pwdata[bbe_pkg::CMD_LONG_BIT];
          next_taken     = 1'b0;
          next_state     = bbe_pkg::st_exec;
        end
        default: next_state = state;
      endcase
    end
    case (state)
      bbe_pkg::st_exec:
      begin
        next_pc     = pc + PC_W'(bbe_pkg::PC_STEP);
        next_cycles = bbe_pkg::CYC_SINGLE;
        next_state  = bbe_pkg::st_idle;
        if (is_branch && cond)
        begin
          next_pc       = target;
          next_taken    = 1'b1;
          next_cycles   = bbe_pkg::CYC_TAKEN;
          next_hold_cnt = bbe_pkg::CYC_TAKEN - bbe_pkg::CYC_SINGLE;
          next_state    = bbe_pkg::st_hold;
        end
        else if ((op == bbe_pkg::op_skip_io_bit_set) && io_rdata[sel])
        begin
          // Skip length depends on the size of the instruction passed over
          next_taken = 1'b1;
          if (long_next)
          begin
            next_pc       = pc + PC_W'(bbe_pkg::SKIP_STEP_TWO);
            next_cycles   = bbe_pkg::CYC_SKIP_LONG;
            next_hold_cnt = bbe_pkg::CYC_SKIP_LONG - bbe_pkg::CYC_SINGLE;
          end
          else
          begin
            next_pc       = pc + PC_W'(bbe_pkg::SKIP_STEP_ONE);
            next_cycles   = bbe_pkg::CYC_SKIP_SHORT;
            next_hold_cnt = bbe_pkg::CYC_SKIP_SHORT - bbe_pkg::CYC_SINGLE;
          end
          next_state = bbe_pkg::st_hold;
        end
        else if ((op == bbe_pkg::op_set_io_bit) || (op == bbe_pkg::op_clear_io_bit))
        begin
          // Read-modify-write keeps the other bits of the register
          if (op == bbe_pkg::op_set_io_bit)
            next_io_wdata = io_rdata | bit_mask;
          else
            next_io_wdata = io_rdata & ~bit_mask;
          next_cycles = bbe_pkg::CYC_IO_BIT;
          next_state  = bbe_pkg::st_io_write;
        end
        else if (is_shift)
        begin
          // Overflow follows N xor C for every shift and rotate
          next_operand                  = shift_res;
          next_flags[bbe_pkg::FLAG_Z]   = (shift_res == '0);
          next_flags[bbe_pkg::FLAG_C]   = shift_c;
          next_flags[bbe_pkg::FLAG_N]   = shift_res[bbe_pkg::DATA_W-1];
          next_flags[bbe_pkg::FLAG_V]   = shift_res[bbe_pkg::DATA_W-1] ^ shift_c;
        end
      end
      bbe_pkg::st_hold:
      begin
        next_hold_cnt = hold_cnt - bbe_pkg::HOLD_LAST;
        if (hold_cnt == bbe_pkg::HOLD_LAST)
          next_state = bbe_pkg::st_idle;
      end
      bbe_pkg::st_io_write: next_state = bbe_pkg::st_idle;
      default:              next_state = next_state;
    endcase
  end

  // State registers; low clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= bbe_pkg::st_idle;
      op        <= bbe_pkg::op_illegal;
      sel       <= '0;
      koff      <= '0;
      long_next <= 1'b0;
      pc        <= '0;
      flags     <= bbe_pkg::FLAGS_RST;
      operand   <= bbe_pkg::OPERAND_RST;
      hold_cnt  <= '0;
      cycles    <= '0;
      taken     <= 1'b0;
      io_addr   <= '0;
      io_wdata  <= '0;
      prdata    <= '0;
      rd_valid  <= 1'b0;
    end
    else if (clk_en)
    begin
      state     <= next_state;
      op        <= next_op;
      sel       <= next_sel;
      koff      <= next_koff;
      long_next <= next_long_next;
      pc        <= next_pc;
      flags     <= next_flags;
      operand   <= next_operand;
      hold_cnt  <= next_hold_cnt;
      cycles    <= next_cycles;
      taken     <= next_taken;
      io_addr   <= next_io_addr;
      io_wdata  <= next_io_wdata;
      prdata    <= next_prdata;
      rd_valid  <= next_rd_valid;
    end
  end

  // Checks; antecedents need clk_en so the next edge really updates
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic go;
  assign go = clk_en && (state == bbe_pkg::st_exec);

  property p_skip_pc;
    go && (op == bbe_pkg::op_skip_io_bit_set) && io_rdata[sel] |=>
      pc == $past(pc) + ($past(long_next) ? PC_W'(3) : PC_W'(2)) && state == bbe_pkg::st_hold;
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip pc step wrong");

  property p_branch_target;
    go && is_branch && cond |=> pc == $past(pc) + PC_W'(1)
      + {{(PC_W - bbe_pkg::CMD_K_W){$past(koff[bbe_pkg::CMD_K_W-1])}}, $past(koff)};
  endproperty
  a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

  property p_taken_two;
    go && is_branch && cond ##1 clk_en |=> state == bbe_pkg::st_idle && cycles == 2'h2;
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

  property p_not_taken;
    go && is_branch && !cond |=> state == bbe_pkg::st_idle && pc == $past(pc) + PC_W'(1);
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch wrong");

  property p_flags_kept;
    go && !is_shift |=> flags == $past(flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  property p_equal;
    go && (op == bbe_pkg::op_branch_when_equal || op == bbe_pkg::op_branch_when_not_equal)
      |=> taken == ($past(flags[bbe_pkg::FLAG_Z]) ^ $past(op == bbe_pkg::op_branch_when_not_equal));
  endproperty
  a_equal: assert property (p_equal) else $error("equal branch wrong");

  property p_carry;
    go && (op == bbe_pkg::op_branch_same_or_higher || op == bbe_pkg::op_branch_when_lower)
      |=> taken == ($past(flags[bbe_pkg::FLAG_C]) ^ $past(op == bbe_pkg::op_branch_same_or_higher));
  endproperty
  a_carry: assert property (p_carry) else $error("carry branch wrong");

  property p_signed;
    go && (op == bbe_pkg::op_branch_signed_less) |=>
      taken == ($past(flags[bbe_pkg::FLAG_N]) != $past(flags[bbe_pkg::FLAG_V]));
  endproperty
  a_signed: assert property (p_signed) else $error("signed less branch wrong");

  property p_set_io;
    go && (op == bbe_pkg::op_set_io_bit) |=> io_we && io_wdata[$past(sel)]
      && ((io_wdata | ($past(bit_mask))) == ($past(io_rdata) | $past(bit_mask)));
  endproperty
  a_set_io: assert property (p_set_io) else $error("set io bit wrong");

  property p_clr_io;
    go && (op == bbe_pkg::op_clear_io_bit) |=> io_we && !io_wdata[$past(sel)];
  endproperty
  a_clr_io: assert property (p_clr_io) else $error("clear io bit wrong");

  property p_rol;
    go && (op == bbe_pkg::op_rotate_left_carry) |=> operand[0] == $past(flags[bbe_pkg::FLAG_C])
      && flags[bbe_pkg::FLAG_C] == $past(operand[bbe_pkg::DATA_W-1]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_lsr;
    go && (op == bbe_pkg::op_shift_right_logical) |=> !operand[bbe_pkg::DATA_W-1]
      && flags[bbe_pkg::FLAG_C] == $past(operand[0]) && !flags[bbe_pkg::FLAG_N];
  endproperty
  a_lsr: assert property (p_lsr) else $error("shift right wrong");

  c_taken: cover property (go && is_branch && cond);
  c_skip_long: cover property (go && op == bbe_pkg::op_skip_io_bit_set && io_rdata[sel] && long_next);
  c_io_write: cover property (io_we);
  c_shift: cover property (go && is_shift);

endmodule : bbe_exec
`default_nettype wire

//--- bbe_io_model.sv
`timescale 1ns/1ps
`default_nettype none
module bbe_io_model (
  input  wire logic       pclk,
  input  wire logic [4:0] io_addr,
  input  wire logic       io_re,
  input  wire logic       io_we,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata
);
  logic [7:0] mem [32];
  logic [7:0] last;
  // Fixed fill so the bench can predict every byte
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 37 + 5);
    last = 8'h00;
  end
  // Idle read bus shows the inverse of the last value, so a late sample fails
  assign io_rdata = io_re ? mem[io_addr] : ~last;
  // Write-back lands only on the strobe edge
  always @(posedge pclk)
  begin
    if (io_re)
      last <= mem[io_addr];
    if (io_we)
      mem[io_addr] <= io_wdata;
  end
endmodule : bbe_io_model
`default_nettype wire

//--- bbe_pkg.sv
package bbe_pkg;

  // Data path and bus widths
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned APB_W    = 32;
  localparam int unsigned ADDR_W   = 8;

  // Register byte offsets on the bus
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_PC      = 8'h04;
  localparam logic [7:0] REG_FLAGS   = 8'h08;
  localparam logic [7:0] REG_OPERAND = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;

  // Reset values
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam logic [7:0] OPERAND_RST = 8'h00;

  // Bit positions inside the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_W     = 5;
  localparam int CMD_SEL_LSB  = 5;
  localparam int CMD_SEL_W    = 3;
  localparam int CMD_K_LSB    = 8;
  localparam int CMD_K_W      = 7;
  localparam int CMD_IO_LSB   = 16;
  localparam int CMD_IO_W     = 5;
  localparam int CMD_LONG_BIT = 24;

  // Status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_CYC_LSB   = 4;
  localparam int STAT_CYC_W     = 2;

  // Cycle figures per instruction outcome
  localparam logic [1:0] CYC_SINGLE     = 2'h1;
  localparam logic [1:0] CYC_TAKEN      = 2'h2;
  localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
  localparam logic [1:0] CYC_SKIP_LONG  = 2'h3;
  localparam logic [1:0] CYC_IO_BIT     = 2'h2;
  localparam logic [1:0] HOLD_LAST      = 2'h1;

  // Program counter steps
  localparam int PC_STEP       = 1;
  localparam int SKIP_STEP_ONE = 2;
  localparam int SKIP_STEP_TWO = 3;

  // Operation codes, numbered from zero in this order
  typedef enum logic [4:0] {
    op_skip_io_bit_set, op_branch_status_bit_set, op_branch_status_bit_clear,
    op_branch_when_equal, op_branch_when_not_equal, op_branch_carry_set,
    op_branch_carry_clear, op_branch_same_or_higher, op_branch_when_lower,
    op_branch_negative, op_branch_positive, op_branch_signed_greater_equal,
    op_branch_signed_less, op_branch_half_carry_set, op_branch_half_carry_clear,
    op_branch_transfer_flag_set, op_branch_transfer_flag_clear,
    op_branch_overflow_set, op_branch_overflow_clear, op_branch_irq_enabled,
    op_branch_irq_disabled, op_set_io_bit, op_clear_io_bit,
    op_shift_left_logical, op_shift_right_logical, op_rotate_left_carry,
    op_rotate_right_carry, op_illegal
  } bbe_op_type;

  typedef enum logic [1:0] {st_idle, st_exec, st_hold, st_io_write} bbe_state_type;

endpackage : bbe_pkg

//--- test_branch_bitop_shift_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_bitop_shift_exec;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, io_re, io_we;
  logic [7:0]  paddr, io_rdata, io_wdata;
  logic [31:0] pwdata, prdata, rdat;
  logic        err;
  logic [4:0]  io_addr;
  logic [31:0] seed = 32'h29;
  logic [31:0] q[$];
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  bbe_exec bbe_exec_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .io_addr(io_addr), .io_re(io_re),
    .io_rdata(io_rdata), .io_we(io_we), .io_wdata(io_wdata));
  bbe_io_model bbe_io_model_inst (.pclk(pclk), .io_addr(io_addr), .io_re(io_re),
    .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Random stalls via clk_en; cycle ceiling cuts a hang short
  always @(posedge pclk)
  begin
    clk_en <= (rnd() & 32'h7) != 32'h0;
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      final_report();
    end
  end
  // Watcher: every completed checked read meets the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && q.size() > 0)
      chk(prdata, q.pop_front());
  initial
  begin
    logic [7:0]  f, r, exf, exr, mb, exm;
    logic [15:0] pc, expc;
    logic [6:0]  k;
    logic [2:0]  s;
    logic [4:0]  a, op;
    logic        lg, tk, c;
    logic [1:0]  cy;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h14, 32'h0);
    chk(32'(err), 32'h1);
    // Refused writes: read-only status and an undefined operation code
    apb(bbe_pkg::REG_STATUS, 1'b1, 32'h0);
    chk(32'(err), 32'h1);
    apb(bbe_pkg::REG_CMD, 1'b1, 32'h1f);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 108; i++)
    begin
      op = 5'(i % 27);
      {f, r, pc} = rnd();
      {lg, a, k, s} = 16'(rnd());
      mb = 8'h01 << s;
      exm = bbe_io_model_inst.mem[a];
      c = f[0];
      {tk, expc, cy, exf, exr} = {1'b0, pc + 16'h1, 2'h1, f, r};
      case (op)
        0: tk = (exm & mb) != 8'h00;
        1, 2: tk = f[s] ^ (op == 2);
        3, 4: tk = f[1] ^ (op == 4);
        5, 8: tk = f[0];
        6, 7: tk = !f[0];
        9, 10: tk = f[2] ^ (op == 10);
        11, 12: tk = f[2] ^ f[3] ^ (op == 11);
        13, 14: tk = f[5] ^ (op == 14);
        15, 16: tk = f[6] ^ (op == 16);
        17, 18: tk = f[3] ^ (op == 18);
        19, 20: tk = f[7] ^ (op == 20);
        21: exm = exm | mb;
        22: exm = exm & ~mb;
        23: {c, exr} = {r, 1'b0};
        24: {exr, c} = {1'b0, r};
        25: {c, exr} = {r, f[0]};
        default: {exr, c} = {f[0], r};
      endcase
      if (op > 20)
        cy = (op < 23) ? 2'h2 : 2'h1;
      if (op > 22)
        exf[3:0] = {exr[7] ^ c, exr[7], exr == 8'h00, c};
      if (tk)
        expc = (op == 0) ? pc + (lg ? 16'h3 : 16'h2) : pc + 16'h1 + {{9{k[6]}}, k};
      if (tk)
        cy = (op == 0) ? (lg ? 2'h3 : 2'h2) : 2'h2;
      apb(bbe_pkg::REG_FLAGS, 1'b1, {24'h0, f});
      apb(bbe_pkg::REG_PC, 1'b1, {16'h0, pc});
      apb(bbe_pkg::REG_OPERAND, 1'b1, {24'h0, r});
      apb(bbe_pkg::REG_CMD, 1'b1, {7'h0, lg, 3'h0, a, 1'b0, k, s, op});
      chk(32'(err), 32'h0);
      apb(bbe_pkg::REG_STATUS, 1'b0, 32'h0);
      while (rdat[0] !== 1'b0)
        apb(bbe_pkg::REG_STATUS, 1'b0, 32'h0);
      rd(bbe_pkg::REG_PC, {16'h0, expc});
      rd(bbe_pkg::REG_FLAGS, {24'h0, exf});
      rd(bbe_pkg::REG_OPERAND, {24'h0, exr});
      rd(bbe_pkg::REG_STATUS, {26'h0, cy, 2'h0, tk, 1'b0});
      chk(32'(bbe_io_model_inst.mem[a]), 32'(exm));
      $display("test op %0d done", op);
    end
    final_report();
  end
endmodule : test_branch_bitop_shift_exec
`default_nettype wire
